// ===== inc/tmt_pkg.sv
// shared constants and types for the timer two control block
package tmt_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] TMT_OFF_CTRL = 8'h00;
  localparam logic [7:0] TMT_OFF_COUNT = 8'h04;
  localparam logic [7:0] TMT_OFF_RELOAD = 8'h08;
  localparam logic [7:0] TMT_OFF_MODE = 8'h0c;
  localparam logic [7:0] TMT_OFF_STAT = 8'h10;
  localparam logic [7:0] TMT_OFF_MASK = 8'h14;
  // ------------------------------------------------------------
  // timer_control_register fields
  // ------------------------------------------------------------
  localparam int TMT_B_OVF = 7;
  localparam int TMT_B_EXT = 6;
  localparam int TMT_B_RXSEL = 5;
  localparam int TMT_B_TXSEL = 4;
  localparam int TMT_B_EXEN = 3;
  localparam int TMT_B_RUN = 2;
  localparam int TMT_B_CSEL = 1;
  localparam int TMT_B_CPRL = 0;
  // status and mask fields
  localparam int TMT_S_OVF = 0;
  localparam int TMT_S_EXT = 1;
  localparam int TMT_S_BAUD = 2;
  // ------------------------------------------------------------
  // reset values and counter top
  // ------------------------------------------------------------
  localparam logic [7:0] TMT_RST_CTRL = 8'h00;
  localparam logic [15:0] TMT_RST_COUNT = 16'h0000;
  localparam logic [15:0] TMT_RST_RELOAD = 16'h0000;
  localparam logic [2:0] TMT_RST_STAT = 3'h0;
  localparam logic [2:0] TMT_RST_MASK = 3'h0;
  localparam logic [15:0] TMT_TOP = 16'hffff;
  // ------------------------------------------------------------
  // cycle counts (pclk is the oscillator)
  // ------------------------------------------------------------
  localparam int TMT_DIV_TIMER = 12;
  localparam int TMT_DIV_BAUD = 2;
  typedef enum logic [3:0] {
    TMT_MODE_OFF = 4'h1,
    TMT_MODE_RELOAD = 4'h2,
    TMT_MODE_CAPTURE = 4'h4,
    TMT_MODE_BAUD = 4'h8
  } tmt_mode_t;
endpackage

// ===== hw/tmt_sync.sv
// two-flop synchroniser with falling edge detect
`timescale 1ns/10ps
module tmt_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic meta;
  logic last;
  // first flop feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      level <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
    end
  end
  assign fall = last & ~level;
endmodule

// ===== hw/tmt_div.sv
// divider giving a one-cycle enable pulse every div_n cycles
`timescale 1ns/10ps
module tmt_div #(
  parameter int DIV_N = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  output logic tick
);
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
    end else if (clr || cnt == 8'(DIV_N - 1)) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign tick = ~clr && cnt == 8'(DIV_N - 1);
endmodule

// ===== hw/tmt_timer.sv
// timer two control, status, counter and apb register slave
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
// What this block does
// - trigger fall with enable sets trigger flag
// - trigger flag cleared only by software outside up/down mode
// - trigger flag requests timer interrupt
// - no trigger interrupt in up/down mode
// - rx select one: rx clock from overflows
// - rx select zero: rx clock from timer1
// - count source zero: count oscillator/12, oscillator/2 in baud mode
// - count source one: count pin falls
// - counts only while run control set
// - capture mode overflow sets overflow flag
// - baud rollover reloads, no overflow flag
module tmt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_pin,
  input wire logic count_pin,
  input wire logic timer1_overflow,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic irq
);
  // ------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic [15:0] count;
  logic [15:0] reload;
  logic down_count_enable;
  logic [2:0] stat;
  logic [2:0] mask;
  logic trig_level;
  logic trig_fall;
  logic cnt_fall;
  logic div12_tick;
  logic div2_tick;
  logic step;
  logic up;
  logic wrap;
  logic ovf_ev;
  logic baud_ev;
  logic ext_ev;
  logic toggle_ev;
  logic wr;
  logic rd;
  logic hit;
  tmt_pkg::tmt_mode_t mode;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
    sel = a == o;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and dividers
  // ------------------------------------------------------------
  tmt_sync u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .pin(trigger_pin),
    .level(trig_level),
    .fall(trig_fall)
  );
  tmt_sync u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .pin(count_pin),
    .level(),
    .fall(cnt_fall)
  );
  // dividers restart while stopped so the first step is a full period
  tmt_div #(.DIV_N(tmt_pkg::TMT_DIV_TIMER)) u_div12 (
    .pclk(pclk),
    .presetn(presetn),
    .clr(~ctrl[tmt_pkg::TMT_B_RUN]),
    .tick(div12_tick)
  );
  tmt_div #(.DIV_N(tmt_pkg::TMT_DIV_BAUD)) u_div2 (
    .pclk(pclk),
    .presetn(presetn),
    .clr(~ctrl[tmt_pkg::TMT_B_RUN]),
    .tick(div2_tick)
  );

  // ------------------------------------------------------------
  // mode selection
  // ------------------------------------------------------------
  always_comb begin
    if (!ctrl[tmt_pkg::TMT_B_RUN]) begin
      mode = tmt_pkg::TMT_MODE_OFF;
    end else if (ctrl[tmt_pkg::TMT_B_RXSEL] |
                 ctrl[tmt_pkg::TMT_B_TXSEL]) begin
      mode = tmt_pkg::TMT_MODE_BAUD;
    end else if (ctrl[tmt_pkg::TMT_B_CPRL]) begin
      mode = tmt_pkg::TMT_MODE_CAPTURE;
    end else begin
      mode = tmt_pkg::TMT_MODE_RELOAD;
    end
  end

  // ------------------------------------------------------------
  // count step and events
  // ------------------------------------------------------------
  logic updown;
  assign updown = down_count_enable && mode == tmt_pkg::TMT_MODE_RELOAD;
  // direction follows the trigger pin only in up/down mode
  assign up = ~updown | trig_level;
  always_comb begin
    case (mode)
      tmt_pkg::TMT_MODE_OFF: step = 1'b0;
      tmt_pkg::TMT_MODE_BAUD:
        step = ctrl[tmt_pkg::TMT_B_CSEL] ? cnt_fall : div2_tick;
      default:
        step = ctrl[tmt_pkg::TMT_B_CSEL] ? cnt_fall : div12_tick;
    endcase
  end
  assign wrap = step && (up ? count == tmt_pkg::TMT_TOP : count == reload);
  assign ovf_ev = wrap && mode != tmt_pkg::TMT_MODE_BAUD;
  // baud rollover gives a tick and a status bit, no overflow flag
  assign baud_ev = wrap && mode == tmt_pkg::TMT_MODE_BAUD;
  assign ext_ev = trig_fall && ctrl[tmt_pkg::TMT_B_EXEN] &&
                  mode != tmt_pkg::TMT_MODE_OFF && ~updown;
  // in up/down mode the trigger flag is a 17th bit
  assign toggle_ev = wrap && updown;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign hit = sel(paddr, tmt_pkg::TMT_OFF_CTRL) |
               sel(paddr, tmt_pkg::TMT_OFF_COUNT) |
               sel(paddr, tmt_pkg::TMT_OFF_RELOAD) |
               sel(paddr, tmt_pkg::TMT_OFF_MODE) |
               sel(paddr, tmt_pkg::TMT_OFF_STAT) |
               sel(paddr, tmt_pkg::TMT_OFF_MASK);
  // zero wait states; unmapped addresses answer with an error
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (wr && sel(paddr, tmt_pkg::TMT_OFF_CTRL)) begin
      next_ctrl = pwdata[7:0];
    end
    // hardware set wins over a clear
    if (ovf_ev) begin
      next_ctrl[tmt_pkg::TMT_B_OVF] = 1'b1;
    end
    if (ext_ev) begin
      next_ctrl[tmt_pkg::TMT_B_EXT] = 1'b1;
    end else if (toggle_ev) begin
      next_ctrl[tmt_pkg::TMT_B_EXT] = ~ctrl[tmt_pkg::TMT_B_EXT];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tmt_pkg::TMT_RST_CTRL;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ------------------------------------------------------------
  // counter and reload/capture register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= tmt_pkg::TMT_RST_COUNT;
    end else if (wr && sel(paddr, tmt_pkg::TMT_OFF_COUNT)) begin
      count <= pwdata[15:0];
    end else if (wrap) begin
      if (!up) begin
        count <= tmt_pkg::TMT_TOP;
      end else if (mode == tmt_pkg::TMT_MODE_CAPTURE) begin
        count <= 16'h0000;
      end else begin
        count <= reload;
      end
    end else if (ext_ev && mode == tmt_pkg::TMT_MODE_RELOAD) begin
      count <= reload;
    end else if (step) begin
      count <= up ? count + 16'h0001 : count - 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload <= tmt_pkg::TMT_RST_RELOAD;
    end else if (ext_ev && mode == tmt_pkg::TMT_MODE_CAPTURE) begin
      // capture keeps counting; hardware capture beats a write
      reload <= count;
    end else if (wr && sel(paddr, tmt_pkg::TMT_OFF_RELOAD)) begin
      reload <= pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_count_enable <= 1'b0;
      mask <= tmt_pkg::TMT_RST_MASK;
    end else if (wr && sel(paddr, tmt_pkg::TMT_OFF_MODE)) begin
      down_count_enable <= pwdata[0];
    end else if (wr && sel(paddr, tmt_pkg::TMT_OFF_MASK)) begin
      mask <= pwdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // interrupt status, read clears, set wins
  // ------------------------------------------------------------
  logic [2:0] ev;
  assign ev = {baud_ev, ext_ev, ovf_ev};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= tmt_pkg::TMT_RST_STAT;
    end else if (rd && sel(paddr, tmt_pkg::TMT_OFF_STAT)) begin
      stat <= ev;
    end else begin
      stat <= stat | ev;
    end
  end
  // irq follows the status value being stored at this same edge
  logic [2:0] next_stat_w;
  assign next_stat_w = (rd && sel(paddr, tmt_pkg::TMT_OFF_STAT)) ?
                       ev : (stat | ev);
  // trigger flag drives the shared request
  // up/down mode masks the trigger flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_stat_w & mask);
    end
  end

  // ------------------------------------------------------------
  // baud clocks
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
    end else begin
      rx_baud_tick <= ctrl[tmt_pkg::TMT_B_RXSEL] ? baud_ev :
                      timer1_overflow;
      tx_baud_tick <= ctrl[tmt_pkg::TMT_B_TXSEL] ? baud_ev :
                      timer1_overflow;
    end
  end

  // ------------------------------------------------------------
  // read data, latched in the setup phase
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        tmt_pkg::TMT_OFF_CTRL: prdata <= {24'h000000, ctrl};
        tmt_pkg::TMT_OFF_COUNT: prdata <= {16'h0000, count};
        tmt_pkg::TMT_OFF_RELOAD: prdata <= {16'h0000, reload};
        tmt_pkg::TMT_OFF_MODE: prdata <= {31'h0, down_count_enable};
        tmt_pkg::TMT_OFF_STAT: prdata <= {29'h0, stat | ev};
        tmt_pkg::TMT_OFF_MASK: prdata <= {29'h0, mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence trig_hit_s;
    trig_fall && ctrl[tmt_pkg::TMT_B_EXEN] && ctrl[tmt_pkg::TMT_B_RUN]
      && !updown;
  endsequence
  sequence ext_set_s;
    ##1 ctrl[tmt_pkg::TMT_B_EXT];
  endsequence

  trig_flag_set_a: assert property (trig_hit_s |-> ext_set_s)
    else $error("trigger flag not set");
  trig_flag_hold_a: assert property (
    ctrl[tmt_pkg::TMT_B_EXT] && !wr && !toggle_ev
      |=> ctrl[tmt_pkg::TMT_B_EXT])
    else $error("trigger flag cleared by hardware");
  trig_irq_a: assert property (
    (trig_hit_s and mask[tmt_pkg::TMT_S_EXT]) |=> irq)
    else $error("trigger event gave no interrupt");
  logic stat_ev_ext;
  assign stat_ev_ext = ev[tmt_pkg::TMT_S_EXT];
  updown_no_irq_a: assert property (
    updown && trig_fall |-> !stat_ev_ext)
    else $error("trigger event in up/down mode");
  rx_own_a: assert property (
    ctrl[tmt_pkg::TMT_B_RXSEL] && baud_ev |=> rx_baud_tick)
    else $error("rx tick missing");
  rx_t1_a: assert property (
    !ctrl[tmt_pkg::TMT_B_RXSEL] |=>
      rx_baud_tick == $past(timer1_overflow))
    else $error("rx tick not from timer1");
  osc12_step_a: assert property (
    step && !ctrl[tmt_pkg::TMT_B_CSEL] &&
      mode != tmt_pkg::TMT_MODE_BAUD |-> div12_tick)
    else $error("timer step off the twelve divider");
  pin_step_a: assert property (
    step && ctrl[tmt_pkg::TMT_B_CSEL] |-> cnt_fall)
    else $error("counter step without pin fall");
  run_off_a: assert property (
    !ctrl[tmt_pkg::TMT_B_RUN] && !wr |=> $stable(count))
    else $error("counting while stopped");
  cap_ovf_a: assert property (
    mode == tmt_pkg::TMT_MODE_CAPTURE && step && count == 16'hffff
      |=> ctrl[tmt_pkg::TMT_B_OVF] && count == 16'h0000)
    else $error("capture overflow not flagged");
  baud_reload_a: assert property (
    baud_ev && !wr |=> count == $past(reload) &&
      $stable(ctrl[tmt_pkg::TMT_B_OVF]))
    else $error("baud rollover wrong");
  mode_sel_a: assert property (
    ctrl[tmt_pkg::TMT_B_RUN] && ctrl[tmt_pkg::TMT_B_TXSEL]
      |-> mode == tmt_pkg::TMT_MODE_BAUD)
    else $error("baud mode not selected");
endmodule

// ===== verif/tmt_far_model.sv
// far side model: trigger and count pins, timer 1 and serial baud taps
`timescale 1ns/10ps
module tmt_far_model (
  input wire logic pclk,
  input wire logic t1_en,
  input wire logic clr,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  output logic trigger_pin,
  output logic count_pin,
  output logic timer1_overflow,
  output int rx_cnt,
  output int tx_cnt,
  output int t1_cnt
);
  int div;
  initial begin
    trigger_pin = 1'b1;
    count_pin = 1'b1;
    timer1_overflow = 1'b0;
    div = 0;
  end
  // ------------------------------------------------------------
  // timer 1 overflow source and serial side tick counters
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    div <= (div == 9) ? 0 : div + 1;
    timer1_overflow <= t1_en && (div == 9);
    t1_cnt <= clr ? 0 : t1_cnt + int'(timer1_overflow);
    rx_cnt <= clr ? 0 : rx_cnt + int'(rx_baud_tick);
    tx_cnt <= clr ? 0 : tx_cnt + int'(tx_baud_tick);
  end
  // ------------------------------------------------------------
  // pin falls
  // ------------------------------------------------------------
  // pins idle high as if pulled up; low held 4 cycles to pass the syncer
  task automatic fall(input bit trig, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (trig) trigger_pin <= 1'b0;
      else count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      trigger_pin <= 1'b1;
      count_pin <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// ===== verif/tb_timer_two_control_register.sv
// self-checking bench for the timer two control block
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_timer_two_control_register;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic trigger_pin, count_pin, timer1_overflow, rx_tick, tx_tick, irq;
  logic t1_en, clr, err;
  int rx_cnt, tx_cnt, t1_cnt, mismatches, checked;
  tmt_timer u_tmt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_pin(trigger_pin), .count_pin(count_pin),
    .timer1_overflow(timer1_overflow), .rx_baud_tick(rx_tick),
    .tx_baud_tick(tx_tick), .irq(irq));
  tmt_far_model u_tmt_far_model (.pclk(pclk), .t1_en(t1_en), .clr(clr),
    .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .trigger_pin(trigger_pin), .count_pin(count_pin),
    .timer1_overflow(timer1_overflow), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt),
    .t1_cnt(t1_cnt));
  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  // request held until the edge that samples pready; watchdog bounds it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_map;
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_0000);
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0000);
    // refusal of an unmapped word
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask
  task automatic t_timer_rate;
    logic [31:0] a;
    apb(1'b1, tmt_pkg::TMT_OFF_COUNT, 32'h0000_0000);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0004);
    repeat (120) @(posedge pclk);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0000);
    apb(1'b0, tmt_pkg::TMT_OFF_COUNT, 32'h0000_0000);
    a = rd;
    `CHK(a >= 32'd10 && a <= 32'd11, 1'b1)
    repeat (40) @(posedge pclk);
    rd_chk(tmt_pkg::TMT_OFF_COUNT, a);
  endtask
  task automatic t_overflow_irq;
    apb(1'b1, tmt_pkg::TMT_OFF_MASK, 32'h0000_0001);
    apb(1'b1, tmt_pkg::TMT_OFF_COUNT, 32'h0000_ffff);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0005);
    repeat (30) @(posedge pclk);
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_0085);
    `CHK(irq, 1'b1)
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0001);
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0000);
  endtask
  task automatic t_counter_pin;
    apb(1'b1, tmt_pkg::TMT_OFF_COUNT, 32'h0000_0000);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0006);
    u_tmt_far_model.fall(1'b0, 5);
    repeat (6) @(posedge pclk);
    rd_chk(tmt_pkg::TMT_OFF_COUNT, 32'h0000_0005);
  endtask
  task automatic t_trigger;
    apb(1'b1, tmt_pkg::TMT_OFF_MASK, 32'h0000_0002);
    apb(1'b1, tmt_pkg::TMT_OFF_COUNT, 32'h0000_1234);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_000f);
    u_tmt_far_model.fall(1'b1, 1);
    rd_chk(tmt_pkg::TMT_OFF_RELOAD, 32'h0000_1234);
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_004f);
    `CHK(irq, 1'b1)
    repeat (50) @(posedge pclk);
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_004f);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_000e);
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_000e);
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0002);
    // auto-reload mode: the fall reloads the count
    apb(1'b1, tmt_pkg::TMT_OFF_RELOAD, 32'h0000_0055);
    u_tmt_far_model.fall(1'b1, 1);
    rd_chk(tmt_pkg::TMT_OFF_COUNT, 32'h0000_0055);
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_004e);
    // enable off: a fall is no trigger
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0006);
    u_tmt_far_model.fall(1'b1, 1);
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_0006);
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0002);
    // up/down mode: no trigger interrupt
    apb(1'b1, tmt_pkg::TMT_OFF_MODE, 32'h0000_0001);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_000e);
    u_tmt_far_model.fall(1'b1, 1);
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    apb(1'b1, tmt_pkg::TMT_OFF_MODE, 32'h0000_0000);
  endtask
  // ticks are counted after the sources stop, so no pulse is in flight
  task automatic t_baud;
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, tmt_pkg::TMT_OFF_RELOAD, 32'h0000_fff0);
    apb(1'b1, tmt_pkg::TMT_OFF_COUNT, 32'h0000_fff0);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    t1_en <= 1'b1;
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0024);
    repeat (200) @(posedge pclk);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0000);
    t1_en <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(rx_cnt >= 6 && rx_cnt <= 7, 1'b1)
    `CHK(tx_cnt == t1_cnt && t1_cnt > 0, 1'b1)
    rd_chk(tmt_pkg::TMT_OFF_CTRL, 32'h0000_0000);
    rd_chk(tmt_pkg::TMT_OFF_STAT, 32'h0000_0004);
    // transmit select alone: baud mode, receive stays on timer 1
    apb(1'b1, tmt_pkg::TMT_OFF_COUNT, 32'h0000_fff0);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    t1_en <= 1'b1;
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0014);
    repeat (200) @(posedge pclk);
    apb(1'b1, tmt_pkg::TMT_OFF_CTRL, 32'h0000_0000);
    t1_en <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(rx_cnt == t1_cnt && t1_cnt > 0, 1'b1)
    `CHK(tx_cnt >= 6 && tx_cnt <= 7, 1'b1)
  endtask
  // ------------------------------------------------------------
  // clock, reset, watchdog and verdict
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // the whole run is about nine hundred cycles; over thirty times that is a hang
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, t1_en, clr} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_timer_rate();
    t_overflow_irq();
    t_counter_pin();
    t_trigger();
    t_baud();
    wrap_up();
  end
endmodule
